// ---- logic/cix_pkg.sv ----
// shared constants and types for the instruction execute subset
package cix_pkg;

  // operation codes presented to the execute unit
  typedef enum logic [4:0] {
    CIX_OP_NONE = 5'h00,
    CIX_OP_JUMP_ON_CARRY = 5'h01,
    CIX_OP_JUMP_ON_NO_CARRY = 5'h02,
    CIX_OP_JUMP_IF_EQUAL = 5'h03,
    CIX_OP_JUMP_IF_NOT_EQUAL = 5'h04,
    CIX_OP_JUMP_IF_NEGATIVE = 5'h05,
    CIX_OP_JUMP_IF_POSITIVE = 5'h06,
    CIX_OP_JUMP_IF_POSITIVE_OR_ZERO = 5'h07,
    CIX_OP_MEMORY_LOAD_TO_A = 5'h08,
    CIX_OP_STACK_POINTER_FROM_B = 5'h09,
    CIX_OP_REGISTER_COPY = 5'h0A,
    CIX_OP_REGISTER_PAIR_LOAD = 5'h0B,
    CIX_OP_PAIR_LOAD_INDEXED = 5'h0C,
    CIX_OP_PERIPHERAL_IN = 5'h0D,
    CIX_OP_PERIPHERAL_OUT = 5'h0E,
    CIX_OP_BYTE_MULTIPLY = 5'h0F,
    CIX_OP_REGISTER_OR = 5'h10,
    CIX_OP_PERIPHERAL_OR_UPDATE = 5'h11,
    CIX_OP_STACK_PULL = 5'h12,
    CIX_OP_STACK_STORE = 5'h13,
    CIX_OP_INTERRUPT_RETURN = 5'h14,
    CIX_OP_SUBROUTINE_RETURN = 5'h15,
    CIX_OP_ROTATE_LEFT = 5'h16
  } cix_op_t;

  // memory addressing forms of the extended load
  typedef enum logic [1:0] {
    CIX_AM_DIRECT = 2'h0,
    CIX_AM_INDEXED = 2'h1,
    CIX_AM_INDIRECT = 2'h2
  } cix_amode_t;

  // sequencer states, one-hot
  typedef enum logic [4:0] {
    CIX_ST_IDLE = 5'b00001,
    CIX_ST_MEM = 5'b00010,
    CIX_ST_PF_READ = 5'b00100,
    CIX_ST_POP = 5'b01000,
    CIX_ST_DONE = 5'b10000
  } cix_state_t;

  // status register bit positions
  localparam int CIX_C_BIT = 7;
  localparam int CIX_N_BIT = 6;
  localparam int CIX_Z_BIT = 5;
  localparam int CIX_MSB_BIT = 7;
  // reset values
  localparam logic [7:0] CIX_SP_RESET = 8'h01;
  localparam logic [7:0] CIX_ST_RESET = 8'h00;
  localparam logic [15:0] CIX_PC_RESET = 16'h0000;
  // pop counts for the return forms
  localparam logic [1:0] CIX_POPS_INTERRUPT_RETURN = 2'h3;
  localparam logic [1:0] CIX_POPS_SUBROUTINE_RETURN = 2'h2;

endpackage : cix_pkg

// ---- logic/cix_flag_unit.sv ----
// flag evaluation helper: condition test and status update from a result byte
`timescale 1ns/10ps
module cix_flag_unit
  import cix_pkg::*;
(
  input wire cix_op_t op,
  input wire logic [7:0] status,
  input wire logic [7:0] value,
  input wire logic carry_in,
  output logic taken,
  output logic [7:0] status_out
);

  logic c;
  logic n;
  logic z;

  // condition table for the relative jumps; other flags are don't care
  always_comb begin
    c = status[CIX_C_BIT];
    n = status[CIX_N_BIT];
    z = status[CIX_Z_BIT];
    case (op)
      CIX_OP_JUMP_ON_CARRY: taken = c;
      CIX_OP_JUMP_ON_NO_CARRY: taken = !c;
      CIX_OP_JUMP_IF_EQUAL: taken = z;
      CIX_OP_JUMP_IF_NOT_EQUAL: taken = !z;
      CIX_OP_JUMP_IF_NEGATIVE: taken = n;
      CIX_OP_JUMP_IF_POSITIVE_OR_ZERO: taken = !n;
      CIX_OP_JUMP_IF_POSITIVE: taken = !n && !z;
      default: taken = 1'b0;
    endcase
  end

  // new status: carry as given, n and z from the value, other bits kept
  always_comb begin
    status_out = status;
    status_out[CIX_C_BIT] = carry_in;
    status_out[CIX_N_BIT] = value[CIX_MSB_BIT];
    status_out[CIX_Z_BIT] = (value == 8'h00);
  end

endmodule : cix_flag_unit

// ---- logic/cix_execute.sv ----
// execute unit for a subset of the 8-bit instruction set
`timescale 1ns/10ps
module cix_execute
  import cix_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire cix_op_t op,
  input wire cix_amode_t amode,
  input wire logic [7:0] src,
  input wire logic [7:0] dst_val,
  input wire logic [7:0] dst_addr,
  input wire logic [15:0] imm16,
  input wire logic [15:0] pair_val,
  input wire logic dst_is_status,
  input wire logic [7:0] a_val,
  input wire logic [7:0] b_val,
  input wire logic [15:0] pc_next,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_rvalid,
  output logic busy,
  output logic done,
  output logic [7:0] sp,
  output logic [7:0] status,
  output logic [15:0] pc,
  output logic pc_load,
  output logic rf_we,
  output logic [7:0] rf_waddr,
  output logic [7:0] rf_wdata,
  output logic rf_we2,
  output logic [7:0] rf_waddr2,
  output logic [7:0] rf_wdata2,
  output logic mem_re,
  output logic mem_we,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic pf_re,
  output logic pf_we
);

  cix_state_t state_reg, state_next;
  cix_op_t op_reg, op_next;
  logic [7:0] sp_reg, sp_next;
  logic [7:0] status_reg, status_next;
  logic [15:0] pc_reg, pc_next_v;
  logic pc_load_reg, pc_load_next;
  logic done_reg, done_next;
  logic rf_we_reg, rf_we_next;
  logic [7:0] rf_waddr_reg, rf_waddr_next;
  logic [7:0] rf_wdata_reg, rf_wdata_next;
  logic rf_we2_reg, rf_we2_next;
  logic [7:0] rf_waddr2_reg, rf_waddr2_next;
  logic [7:0] rf_wdata2_reg, rf_wdata2_next;
  logic mem_re_reg, mem_re_next;
  logic mem_we_reg, mem_we_next;
  logic [15:0] mem_addr_reg, mem_addr_next;
  logic [7:0] mem_wdata_reg, mem_wdata_next;
  logic pf_re_reg, pf_re_next;
  logic pf_we_reg, pf_we_next;
  logic [1:0] pops_reg, pops_next;
  logic [7:0] dst_reg, dst_next;
  logic [7:0] opnd_reg, opnd_next;
  logic dst_st_reg, dst_st_next;

  logic taken;
  logic [7:0] flag_value;
  logic flag_carry;
  logic [7:0] status_upd;
  logic [15:0] product;
  logic [7:0] rotated;
  logic [15:0] pair_sum;
  logic [7:0] or_val;

  // jump conditions and status update shared by most operations
  cix_flag_unit u_flags (
    .op(op),
    .status(status_reg),
    .value(flag_value),
    .carry_in(flag_carry),
    .taken(taken),
    .status_out(status_upd)
  );

  // arithmetic shared by the single-cycle operations
  always_comb begin
    product = src * dst_val;
    rotated = {dst_val[6:0], dst_val[7]};
    pair_sum = imm16 + {8'h00, b_val};
    or_val = src | dst_val;
  end

  // value and carry fed to the flag unit for the op now being started or finished
  always_comb begin
    flag_carry = 1'b0;
    flag_value = src;
    if (state_reg == CIX_ST_IDLE) begin
      case (op)
        CIX_OP_BYTE_MULTIPLY: flag_value = product[15:8];
        CIX_OP_REGISTER_OR: flag_value = or_val;
        CIX_OP_REGISTER_PAIR_LOAD: flag_value = pair_val[15:8];
        CIX_OP_PAIR_LOAD_INDEXED: flag_value = pair_sum[15:8];
        CIX_OP_ROTATE_LEFT: begin
          flag_value = rotated;
          flag_carry = dst_val[7];
        end
        default: flag_value = src;
      endcase
    end else if (op_reg == CIX_OP_PERIPHERAL_OR_UPDATE) begin
      flag_value = opnd_reg | mem_rdata;
    end else if (op_reg == CIX_OP_PERIPHERAL_OUT) begin
      // an output takes its flags from the byte written, not from the dummy read
      flag_value = opnd_reg;
    end else begin
      flag_value = mem_rdata;
    end
  end

  // next-state logic for the sequencer and all register outputs
  always_comb begin
    state_next = state_reg;
    op_next = op_reg;
    sp_next = sp_reg;
    status_next = status_reg;
    pc_next_v = pc_reg;
    pc_load_next = 1'b0;
    done_next = 1'b0;
    rf_we_next = 1'b0;
    rf_waddr_next = rf_waddr_reg;
    rf_wdata_next = rf_wdata_reg;
    rf_we2_next = 1'b0;
    rf_waddr2_next = rf_waddr2_reg;
    rf_wdata2_next = rf_wdata2_reg;
    mem_re_next = 1'b0;
    mem_we_next = 1'b0;
    mem_addr_next = mem_addr_reg;
    mem_wdata_next = mem_wdata_reg;
    pf_re_next = 1'b0;
    pf_we_next = 1'b0;
    pops_next = pops_reg;
    dst_next = dst_reg;
    opnd_next = opnd_reg;
    dst_st_next = dst_st_reg;
    case (state_reg)
      CIX_ST_IDLE: begin
        if (start) begin
          op_next = op;
          dst_next = dst_addr;
          opnd_next = src;
          dst_st_next = dst_is_status;
          state_next = CIX_ST_DONE;
          case (op)
            CIX_OP_JUMP_ON_CARRY, CIX_OP_JUMP_ON_NO_CARRY, CIX_OP_JUMP_IF_EQUAL,
            CIX_OP_JUMP_IF_NOT_EQUAL, CIX_OP_JUMP_IF_NEGATIVE,
            CIX_OP_JUMP_IF_POSITIVE, CIX_OP_JUMP_IF_POSITIVE_OR_ZERO: begin
              if (taken) begin
                pc_next_v = pc_next + {{8{src[7]}}, src};
                pc_load_next = 1'b1;
              end
            end
            CIX_OP_MEMORY_LOAD_TO_A: begin
              // address formed by mode; indirect pair arrives on pair_val
              case (amode)
                CIX_AM_INDEXED: mem_addr_next = imm16 + {8'h00, b_val};
                CIX_AM_INDIRECT: mem_addr_next = pair_val;
                default: mem_addr_next = imm16;
              endcase
              mem_re_next = 1'b1;
              state_next = CIX_ST_MEM;
            end
            CIX_OP_STACK_POINTER_FROM_B: sp_next = b_val;
            CIX_OP_REGISTER_COPY, CIX_OP_REGISTER_OR, CIX_OP_ROTATE_LEFT: begin
              rf_we_next = 1'b1;
              rf_waddr_next = dst_addr;
              rf_wdata_next = (op == CIX_OP_REGISTER_COPY) ? src :
                              (op == CIX_OP_REGISTER_OR) ? or_val : rotated;
              status_next = status_upd;
            end
            CIX_OP_REGISTER_PAIR_LOAD, CIX_OP_PAIR_LOAD_INDEXED: begin
              rf_we_next = 1'b1;
              rf_waddr_next = dst_addr;
              rf_we2_next = 1'b1;
              rf_waddr2_next = dst_addr - 8'h01;
              if (op == CIX_OP_PAIR_LOAD_INDEXED) begin
                rf_wdata_next = pair_sum[7:0];
                rf_wdata2_next = pair_sum[15:8];
              end else begin
                rf_wdata_next = pair_val[7:0];
                rf_wdata2_next = pair_val[15:8];
              end
              status_next = status_upd;
            end
            CIX_OP_BYTE_MULTIPLY: begin
              // a and b are ports of the register file, taken by caller as pair writes
              rf_we_next = 1'b1;
              rf_waddr_next = 8'h00;
              rf_wdata_next = product[15:8];
              rf_we2_next = 1'b1;
              rf_waddr2_next = 8'h01;
              rf_wdata2_next = product[7:0];
              status_next = status_upd;
            end
            CIX_OP_PERIPHERAL_IN, CIX_OP_PERIPHERAL_OUT, CIX_OP_PERIPHERAL_OR_UPDATE: begin
              // read always precedes any write, even for a pure output
              mem_addr_next = {8'h00, dst_addr};
              pf_re_next = 1'b1;
              state_next = CIX_ST_PF_READ;
            end
            CIX_OP_STACK_STORE: begin
              sp_next = sp_reg + 8'h01;
              mem_addr_next = {8'h00, sp_reg + 8'h01};
              mem_wdata_next = src;
              mem_we_next = 1'b1;
              status_next = status_upd;
            end
            CIX_OP_STACK_PULL, CIX_OP_INTERRUPT_RETURN, CIX_OP_SUBROUTINE_RETURN: begin
              pops_next = (op == CIX_OP_INTERRUPT_RETURN) ? CIX_POPS_INTERRUPT_RETURN :
                          (op == CIX_OP_SUBROUTINE_RETURN) ? CIX_POPS_SUBROUTINE_RETURN : 2'h1;
              mem_addr_next = {8'h00, sp_reg};
              mem_re_next = 1'b1;
              state_next = CIX_ST_POP;
            end
            default: state_next = CIX_ST_DONE;
          endcase
        end
      end
      CIX_ST_MEM: begin
        if (mem_rvalid) begin
          rf_we_next = 1'b1;
          rf_waddr_next = 8'h00;
          rf_wdata_next = mem_rdata;
          status_next = status_upd;
          state_next = CIX_ST_DONE;
        end
      end
      CIX_ST_PF_READ: begin
        if (mem_rvalid) begin
          state_next = CIX_ST_DONE;
          case (op_reg)
            CIX_OP_PERIPHERAL_IN: begin
              rf_we_next = 1'b1;
              rf_waddr_next = opnd_reg;
              rf_wdata_next = mem_rdata;
              status_next = status_upd;
            end
            CIX_OP_PERIPHERAL_OR_UPDATE: begin
              pf_we_next = 1'b1;
              mem_wdata_next = opnd_reg | mem_rdata;
              status_next = status_upd;
            end
            default: begin
              pf_we_next = 1'b1;
              mem_wdata_next = opnd_reg;
              status_next = status_upd;
            end
          endcase
        end
      end
      CIX_ST_POP: begin
        if (mem_rvalid) begin
          sp_next = sp_reg - 8'h01;
          if (op_reg == CIX_OP_STACK_PULL) begin
            if (dst_st_reg) begin
              status_next = mem_rdata;
            end else begin
              rf_we_next = 1'b1;
              rf_waddr_next = dst_reg;
              rf_wdata_next = mem_rdata;
              status_next = status_upd;
            end
          end else if (pops_reg == CIX_POPS_INTERRUPT_RETURN - 2'h2 && op_reg == CIX_OP_INTERRUPT_RETURN) begin
            status_next = mem_rdata;
          end else if (pops_reg[0] == (op_reg == CIX_OP_INTERRUPT_RETURN)) begin
            pc_next_v = {pc_reg[15:8], mem_rdata};
          end else begin
            pc_next_v = {mem_rdata, pc_reg[7:0]};
          end
          pops_next = pops_reg - 2'h1;
          if (pops_reg == 2'h1) begin
            state_next = CIX_ST_DONE;
            pc_load_next = (op_reg != CIX_OP_STACK_PULL);
          end else begin
            mem_addr_next = {8'h00, sp_reg - 8'h01};
            mem_re_next = 1'b1;
          end
        end
      end
      CIX_ST_DONE: begin
        done_next = 1'b1;
        state_next = CIX_ST_IDLE;
      end
      default: state_next = CIX_ST_IDLE;
    endcase
  end

  // state registers only
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= CIX_ST_IDLE;
      op_reg <= CIX_OP_NONE;
      sp_reg <= CIX_SP_RESET;
      status_reg <= CIX_ST_RESET;
      pc_reg <= CIX_PC_RESET;
      pc_load_reg <= 1'b0;
      done_reg <= 1'b0;
      rf_we_reg <= 1'b0;
      rf_waddr_reg <= 8'h00;
      rf_wdata_reg <= 8'h00;
      rf_we2_reg <= 1'b0;
      rf_waddr2_reg <= 8'h00;
      rf_wdata2_reg <= 8'h00;
      mem_re_reg <= 1'b0;
      mem_we_reg <= 1'b0;
      mem_addr_reg <= 16'h0000;
      mem_wdata_reg <= 8'h00;
      pf_re_reg <= 1'b0;
      pf_we_reg <= 1'b0;
      pops_reg <= 2'h0;
      dst_reg <= 8'h00;
      opnd_reg <= 8'h00;
      dst_st_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      op_reg <= op_next;
      sp_reg <= sp_next;
      status_reg <= status_next;
      pc_reg <= pc_next_v;
      pc_load_reg <= pc_load_next;
      done_reg <= done_next;
      rf_we_reg <= rf_we_next;
      rf_waddr_reg <= rf_waddr_next;
      rf_wdata_reg <= rf_wdata_next;
      rf_we2_reg <= rf_we2_next;
      rf_waddr2_reg <= rf_waddr2_next;
      rf_wdata2_reg <= rf_wdata2_next;
      mem_re_reg <= mem_re_next;
      mem_we_reg <= mem_we_next;
      mem_addr_reg <= mem_addr_next;
      mem_wdata_reg <= mem_wdata_next;
      pf_re_reg <= pf_re_next;
      pf_we_reg <= pf_we_next;
      pops_reg <= pops_next;
      dst_reg <= dst_next;
      opnd_reg <= opnd_next;
      dst_st_reg <= dst_st_next;
    end
  end

  // outputs straight from flip-flops, except busy decoded from the state
  always_comb begin
    busy = (state_reg != CIX_ST_IDLE);
    done = done_reg;
    sp = sp_reg;
    status = status_reg;
    pc = pc_reg;
    pc_load = pc_load_reg;
    rf_we = rf_we_reg;
    rf_waddr = rf_waddr_reg;
    rf_wdata = rf_wdata_reg;
    rf_we2 = rf_we2_reg;
    rf_waddr2 = rf_waddr2_reg;
    rf_wdata2 = rf_wdata2_reg;
    mem_re = mem_re_reg;
    mem_we = mem_we_reg;
    mem_addr = mem_addr_reg;
    mem_wdata = mem_wdata_reg;
    pf_re = pf_re_reg;
    pf_we = pf_we_reg;
  end

  // stack pointer load leaves status alone
  property p_sp_from_b;
    @(posedge clk) disable iff (!rst_n)
      (state_reg == CIX_ST_IDLE && start && op == CIX_OP_STACK_POINTER_FROM_B)
        |=> (sp == $past(b_val) && status == $past(status_reg));
  endproperty
  a_sp_from_b: assert property (p_sp_from_b) else $error("sp load wrong");

  // a peripheral write is always preceded by a read
  property p_pf_read_first;
    @(posedge clk) disable iff (!rst_n)
      pf_we |-> $past(state_reg == CIX_ST_PF_READ);
  endproperty
  a_pf_read_first: assert property (p_pf_read_first) else $error("pf write without read");

  // push raises sp by one
  property p_push_sp;
    @(posedge clk) disable iff (!rst_n)
      (state_reg == CIX_ST_IDLE && start && op == CIX_OP_STACK_STORE)
        |=> (sp == $past(sp_reg) + 8'h01 && mem_we && status[CIX_C_BIT] == 1'b0);
  endproperty
  a_push_sp: assert property (p_push_sp) else $error("push wrong");

  // positive jump never taken with n or z set
  property p_jp;
    @(posedge clk) disable iff (!rst_n)
      (state_reg == CIX_ST_IDLE && start && op == CIX_OP_JUMP_IF_POSITIVE
        && (status_reg[CIX_N_BIT] || status_reg[CIX_Z_BIT])) |=> !pc_load;
  endproperty
  a_jp: assert property (p_jp) else $error("positive jump taken wrongly");

  // rotate result and carry both come from the old top bit
  property p_rotate;
    @(posedge clk) disable iff (!rst_n)
      (state_reg == CIX_ST_IDLE && start && op == CIX_OP_ROTATE_LEFT)
        |=> (rf_we && rf_wdata == {$past(dst_val[6:0]), $past(dst_val[7])}
          && status[CIX_C_BIT] == $past(dst_val[7]));
  endproperty
  a_rotate: assert property (p_rotate) else $error("rotate wrong");

  // full product split over both write ports, high byte to a
  property p_multiply;
    @(posedge clk) disable iff (!rst_n)
      (state_reg == CIX_ST_IDLE && start && op == CIX_OP_BYTE_MULTIPLY)
        |=> ({rf_wdata, rf_wdata2} == $past(src) * $past(dst_val) && rf_waddr == 8'h00 && rf_waddr2 == 8'h01);
  endproperty
  a_multiply: assert property (p_multiply) else $error("multiply wrong");

  // a peripheral write carries the flags of the byte written
  property p_pf_flags;
    @(posedge clk) disable iff (!rst_n)
      pf_we |-> (status[CIX_N_BIT] == mem_wdata[CIX_MSB_BIT] && status[CIX_Z_BIT] == (mem_wdata == 8'h00)
        && !status[CIX_C_BIT]);
  endproperty
  a_pf_flags: assert property (p_pf_flags) else $error("peripheral flags wrong");

endmodule : cix_execute

// ---- verification/tb_top.sv ----
// self-checking bench for the instruction execute subset
`timescale 1ns/10ps
module tb_top;
  import cix_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic start = 1'b0;
  cix_op_t op = CIX_OP_NONE;
  cix_amode_t amode = CIX_AM_DIRECT;
  logic [7:0] src = 8'h00;
  logic [7:0] dst_val = 8'h00;
  logic [7:0] dst_addr = 8'h00;
  logic [7:0] b_val = 8'h00;
  logic [7:0] rdata = 8'h00;
  logic [15:0] imm16 = 16'h0000;
  logic [15:0] pair_val = 16'h0000;
  logic [15:0] pc_next = 16'h0000;
  logic dst_is_status = 1'b0;
  logic rvalid = 1'b0;
  logic busy, done, pc_load, rf_we, rf_we2, mem_re, mem_we, pf_re, pf_we;
  logic [7:0] sp, status, rf_waddr, rf_wdata, rf_waddr2, rf_wdata2, mem_wdata;
  logic [15:0] pc, mem_addr;
  // monitor state; image and seen flags cleared at each issue
  logic [7:0] rf_img [0:255];
  logic pc_seen, pf_rd, pf_ok, re_seen;
  logic [7:0] pf_waddr, pf_wdata, we_data;
  logic [15:0] re_addr, we_addr;
  logic [7:0] rd_q [$];
  int err_count = 0;
  int total_checks = 0;
  int cyc = 0;

  cix_execute u_dut (.clk(clk), .rst_n(rst_n), .start(start), .op(op), .amode(amode), .src(src),
    .dst_val(dst_val), .dst_addr(dst_addr), .imm16(imm16), .pair_val(pair_val),
    .dst_is_status(dst_is_status), .a_val(8'h00), .b_val(b_val), .pc_next(pc_next),
    .mem_rdata(rdata), .mem_rvalid(rvalid), .busy(busy), .done(done), .sp(sp), .status(status),
    .pc(pc), .pc_load(pc_load), .rf_we(rf_we), .rf_waddr(rf_waddr), .rf_wdata(rf_wdata),
    .rf_we2(rf_we2), .rf_waddr2(rf_waddr2), .rf_wdata2(rf_wdata2), .mem_re(mem_re),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .pf_re(pf_re), .pf_we(pf_we));

  always #4 clk = ~clk;

  // answer each read strobe a cycle later; data line scrambles when idle so stale bytes never match
  always @(posedge clk) begin
    rvalid <= 1'b0;
    rdata <= ~rdata;
    if (mem_re === 1'b1 || pf_re === 1'b1) begin
      rvalid <= 1'b1;
      rdata <= rd_q.pop_front();
    end
    if (rf_we === 1'b1) rf_img[rf_waddr] <= rf_wdata;
    if (rf_we2 === 1'b1) rf_img[rf_waddr2] <= rf_wdata2;
    if (pc_load === 1'b1) pc_seen <= 1'b1;
    if (pf_re === 1'b1) pf_rd <= 1'b1;
    if (pf_we === 1'b1) begin
      pf_ok <= pf_rd;
      pf_waddr <= mem_addr[7:0];
      pf_wdata <= mem_wdata;
    end
    if (mem_re === 1'b1 && re_seen !== 1'b1) begin
      re_seen <= 1'b1;
      re_addr <= mem_addr;
    end
    if (mem_we === 1'b1) begin
      we_addr <= mem_addr;
      we_data <= mem_wdata;
    end
  end

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      bad("timeout");
      tally_and_finish();
    end
  end

  task automatic bad(input string m);
    err_count++;
    $display("BAD %0t %s", $time, m);
  endtask : bad

  task automatic chk1(input logic g, input logic e, input string m);
    total_checks++;
    if (g !== e) bad(m);
  endtask : chk1

  task automatic chk8(input logic [7:0] g, input logic [7:0] e, input string m);
    total_checks++;
    if (g !== e) bad(m);
  endtask : chk8

  task automatic chk16(input logic [15:0] g, input logic [15:0] e, input string m);
    total_checks++;
    if (g !== e) bad(m);
  endtask : chk16

  // negative and zero must follow the given byte
  task automatic chk_nz(input logic [7:0] v);
    chk8({6'h00, status[6:5]}, {6'h00, v[7], v == 8'h00}, "n z flags");
  endtask : chk_nz

  // one issue: start for a single cycle, then a bounded wait for done
  task automatic run(input cix_op_t o);
    int n;
    @(posedge clk);
    op <= o;
    start <= 1'b1;
    rf_img <= '{default: 8'hXX};
    pc_seen <= 1'b0;
    pf_rd <= 1'b0;
    pf_ok <= 1'b0;
    re_seen <= 1'b0;
    @(posedge clk);
    start <= 1'b0;
    @(posedge clk);
    chk1(busy, 1'b1, "not busy");
    n = 0;
    while (done !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    chk1(done, 1'b1, "no done");
  endtask : run

  // every flag combination against every conditional jump, each jump at one offset extreme
  task automatic t_jumps();
    logic [7:0] s;
    logic tk;
    for (int f = 0; f < 8; f++) begin
      s = {f[2:0], 5'h00};
      rd_q.push_back(s);
      dst_is_status <= 1'b1;
      run(CIX_OP_STACK_PULL);
      chk8(status, s, "status pull");
      dst_is_status <= 1'b0;
      for (int j = 1; j < 8; j++) begin
        src <= j[0] ? 8'h80 : 8'h7F;
        pc_next <= 16'h1000;
        case (j)
          1: tk = s[7];
          2: tk = !s[7];
          3: tk = s[5];
          4: tk = !s[5];
          5: tk = s[6];
          6: tk = !s[6] && !s[5];
          default: tk = !s[6];
        endcase
        run(cix_op_t'(j));
        chk1(pc_seen, tk, "jump decision");
        if (tk) chk16(pc, j[0] ? 16'h0F80 : 16'h107F, "jump target");
      end
    end
  endtask : t_jumps

  // carry is set on entry, so the clear is visible
  task automatic t_copy();
    src <= 8'h00;
    dst_addr <= 8'h21;
    run(CIX_OP_REGISTER_COPY);
    chk8(rf_img[8'h21], 8'h00, "copy data");
    chk1(status[7], 1'b0, "copy carry");
    chk_nz(8'h00);
  endtask : t_copy

  // three addressing forms, indexed with a carry into the high byte
  task automatic t_load();
    logic [15:0] ea [3];
    logic [7:0] d [3];
    ea = '{16'h12F0, 16'h1310, 16'hC0DE};
    d = '{8'h80, 8'h00, 8'h7F};
    imm16 <= 16'h12F0;
    b_val <= 8'h20;
    pair_val <= 16'hC0DE;
    for (int m = 0; m < 3; m++) begin
      amode <= cix_amode_t'(m);
      rd_q.push_back(d[m]);
      run(CIX_OP_MEMORY_LOAD_TO_A);
      chk16(re_addr, ea[m], "load address");
      chk8(rf_img[8'h00], d[m], "load data");
      chk_nz(d[m]);
    end
  endtask : t_load

  task automatic t_pairs();
    dst_addr <= 8'h03;
    imm16 <= 16'h8001;
    pair_val <= 16'h8001;
    run(CIX_OP_REGISTER_PAIR_LOAD);
    chk8(rf_img[8'h03], 8'h01, "pair low");
    chk8(rf_img[8'h02], 8'h80, "pair high");
    chk_nz(8'h80);
    imm16 <= 16'h12F0;
    pair_val <= 16'hFFFF;
    run(CIX_OP_PAIR_LOAD_INDEXED);
    chk8(rf_img[8'h03], 8'h10, "index low");
    chk8(rf_img[8'h02], 8'h13, "index high");
  endtask : t_pairs

  // output, input and or-update all read the location first
  task automatic t_periph();
    src <= 8'h00;
    dst_addr <= 8'h26;
    rd_q.push_back(8'hA5);
    run(CIX_OP_PERIPHERAL_OUT);
    chk1(pf_ok, 1'b1, "out read first");
    chk8(pf_waddr, 8'h26, "out addr");
    chk8(pf_wdata, 8'h00, "out data");
    chk_nz(8'h00);
    src <= 8'h05;
    dst_addr <= 8'h04;
    rd_q.push_back(8'h90);
    run(CIX_OP_PERIPHERAL_IN);
    chk8(rf_img[8'h05], 8'h90, "in data");
    chk1(pf_rd, 1'b1, "in read");
    src <= 8'h01;
    dst_addr <= 8'h30;
    rd_q.push_back(8'h80);
    run(CIX_OP_PERIPHERAL_OR_UPDATE);
    chk1(pf_ok, 1'b1, "or read first");
    chk8(pf_waddr, 8'h30, "or addr");
    chk8(pf_wdata, 8'h81, "or data");
    chk_nz(8'h81);
  endtask : t_periph

  // rotate ends on 0x93 so carry is set before the register or
  task automatic t_arith();
    logic [7:0] v [3];
    v = '{8'h00, 8'h80, 8'h93};
    src <= 8'hFF;
    dst_val <= 8'hFF;
    run(CIX_OP_BYTE_MULTIPLY);
    chk8(rf_img[8'h00], 8'hFE, "product high");
    chk8(rf_img[8'h01], 8'h01, "product low");
    chk_nz(8'hFE);
    dst_addr <= 8'h0B;
    for (int k = 0; k < 3; k++) begin
      dst_val <= v[k];
      run(CIX_OP_ROTATE_LEFT);
      chk8(rf_img[8'h0B], {v[k][6:0], v[k][7]}, "rotate data");
      chk1(status[7], v[k][7], "rotate carry");
      chk_nz({v[k][6:0], v[k][7]});
    end
    src <= 8'h0F;
    dst_val <= 8'hF0;
    dst_addr <= 8'h10;
    run(CIX_OP_REGISTER_OR);
    chk8(rf_img[8'h10], 8'hFF, "or data");
    chk1(status[7], 1'b0, "or carry");
    chk_nz(8'hFF);
  endtask : t_arith

  // stack pointer load, push, pull and both returns
  task automatic t_stack();
    logic [7:0] s0;
    s0 = status;
    b_val <= 8'h5A;
    run(CIX_OP_STACK_POINTER_FROM_B);
    chk8(sp, 8'h5A, "sp load");
    chk8(status, s0, "sp load flags");
    src <= 8'h80;
    run(CIX_OP_STACK_STORE);
    chk8(sp, 8'h5B, "push sp");
    chk16(we_addr, 16'h005B, "push addr");
    chk8(we_data, 8'h80, "push data");
    chk_nz(8'h80);
    dst_addr <= 8'h07;
    rd_q.push_back(8'h00);
    run(CIX_OP_STACK_PULL);
    chk16(re_addr, 16'h005B, "pull addr");
    chk8(rf_img[8'h07], 8'h00, "pull data");
    chk8(sp, 8'h5A, "pull sp");
    chk_nz(8'h00);
    rd_q = '{8'h34, 8'h12, 8'hA0};
    run(CIX_OP_INTERRUPT_RETURN);
    chk16(pc, 16'h1234, "interrupt_return pc");
    chk8(status, 8'hA0, "interrupt_return status");
    chk8(sp, 8'h57, "interrupt_return sp");
    chk1(pc_seen, 1'b1, "interrupt_return load");
    rd_q = '{8'h78, 8'h56};
    run(CIX_OP_SUBROUTINE_RETURN);
    chk16(pc, 16'h5678, "subroutine_return pc");
    chk8(status, 8'hA0, "subroutine_return flags");
    chk8(sp, 8'h55, "subroutine_return sp");
  endtask : t_stack

  task automatic tally_and_finish();
    if (err_count == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk8(sp, 8'h01, "sp reset");
    chk8(status, 8'h00, "status reset");
    t_jumps();
    t_copy();
    t_load();
    t_pairs();
    t_periph();
    t_arith();
    t_stack();
    tally_and_finish();
  end
endmodule : tb_top
